// >>> asc_pkg.sv
// package: timing counts and pin widths for the async sram host controller
`default_nettype none
package asc_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 32768;
	localparam int CLK_PERIOD_NS = 8;
	// timing figures in ns
	localparam int WRITE_CYCLE_NS = 70;
	localparam int WE_PULSE_NS = 50;
	localparam int WRITE_DATA_SETUP_TIME_NS = 30;
	localparam int WRITE_LOW_TO_FLOAT_DELAY_NS = 25;
	localparam int READ_CYCLE_NS = 70;
	localparam int CE_HIGH_TO_FLOAT_NS = 25;
	// least times round up to whole cycles
	localparam int WE_PULSE_CYC =
		(WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_MIN_CYC =
		(WRITE_LOW_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_TIME_NS
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYCLE_CYC =
		(WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_CYC =
		(WE_PULSE_CYC > WR_MIN_CYC) ? WE_PULSE_CYC : WR_MIN_CYC;
	localparam int RD_CYCLE_CYC =
		(READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC =
		(CE_HIGH_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 5;
	typedef enum logic [4:0] {
		ASC_IDLE  = 5'b00001,
		ASC_WRITE = 5'b00010,
		ASC_WEND  = 5'b00100,
		ASC_READ  = 5'b01000,
		ASC_TURN  = 5'b10000
	} asc_state_e;
endpackage
`default_nettype wire

// >>> asc_host.sv
// module: host controller driving an asynchronous byte-wide static memory
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - write happens only during overlap of chip-select low and write-strobe low
// - host keeps write data valid around the terminating rising strobe edge
// - strobe-controlled write with output-drive low lasts float delay plus setup
// - host never drives data pins while the device drives them
module asc_host #(
	parameter int WR_CYC = asc_pkg::WR_PULSE_CYC,
	parameter int RD_CYC = asc_pkg::RD_CYCLE_CYC,
	parameter int GAP_CYC = asc_pkg::TURN_CYC
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        clk_en,
	input  wire logic                        req_valid,
	input  wire logic                        req_write,
	input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
	input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
	output logic                             req_ready,
	output logic                             rsp_valid,
	output logic      [asc_pkg::DATA_W-1:0]  rsp_rdata,
	output logic      [asc_pkg::ADDR_W-1:0]  mem_addr,
	output logic                             mem_chip_sel_n,
	output logic                             mem_write_n,
	output logic                             mem_out_drive_n,
	input  wire logic [asc_pkg::DATA_W-1:0]  mem_data_i,
	output logic      [asc_pkg::DATA_W-1:0]  mem_data_o,
	output logic                             mem_data_oe
);

	localparam logic [asc_pkg::CNT_W-1:0] WR_LAST =
		asc_pkg::CNT_W'(WR_CYC - 1);
	localparam logic [asc_pkg::CNT_W-1:0] RD_LAST =
		asc_pkg::CNT_W'(RD_CYC - 1);
	localparam logic [asc_pkg::CNT_W-1:0] GAP_LAST =
		asc_pkg::CNT_W'(GAP_CYC - 1);

	// ==========================================================
	// sequencer
	// one request at a time: a write runs idle, write, wend, idle and
	// a read runs idle, read, turn, idle; the counter times write, read and turn
	// limitation: clk_en low stretches only the pin phase in progress, by the
	// stalled cycles, so the device only ever sees longer, never shorter, times
	asc_pkg::asc_state_e          state_reg;
	asc_pkg::asc_state_e          state_next;
	logic [asc_pkg::CNT_W-1:0]    cnt_reg;
	logic                         cnt_done;

	always_comb begin
		unique case (state_reg)
			asc_pkg::ASC_WRITE: cnt_done = (cnt_reg == WR_LAST);
			asc_pkg::ASC_READ:  cnt_done = (cnt_reg == RD_LAST);
			asc_pkg::ASC_TURN:  cnt_done = (cnt_reg == GAP_LAST);
			default:            cnt_done = 1'b1;
		endcase
	end

	assign req_ready = (state_reg == asc_pkg::ASC_IDLE) && clk_en;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			asc_pkg::ASC_IDLE:
				if (req_valid) begin
					state_next = req_write ? asc_pkg::ASC_WRITE
						: asc_pkg::ASC_READ;
				end
			asc_pkg::ASC_WRITE:
				if (cnt_done) begin
					state_next = asc_pkg::ASC_WEND;
				end
			asc_pkg::ASC_WEND:
				state_next = asc_pkg::ASC_IDLE;
			asc_pkg::ASC_READ:
				if (cnt_done) begin
					state_next = asc_pkg::ASC_TURN;
				end
			asc_pkg::ASC_TURN:
				if (cnt_done) begin
					state_next = asc_pkg::ASC_IDLE;
				end
			default:
				state_next = asc_pkg::ASC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= asc_pkg::ASC_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_reg <= '0;
		end else if (clk_en) begin
			if (state_next != state_reg) begin
				cnt_reg <= '0;
			end else if (!cnt_done) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	// ==========================================================
	// memory pins
	// address and data are latched at acceptance and held to the end
	// so setup and hold sit around the write-strobe rise, not chip-select
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_addr   <= '0;
			mem_data_o <= '0;
		end else if (clk_en && req_ready && req_valid) begin
			mem_addr <= req_addr;
			mem_data_o <= req_wdata;
		end
	end

	// ==========================================================
	// pin decode
	// one place decides which states open each pin, so the strobes
	// and the data drive cannot drift apart when states are added
	function automatic logic sel_on(
		input asc_pkg::asc_state_e st
	);
		sel_on = (st == asc_pkg::ASC_WRITE)
			|| (st == asc_pkg::ASC_WEND)
			|| (st == asc_pkg::ASC_READ);
	endfunction

	function automatic logic write_on(
		input asc_pkg::asc_state_e st
	);
		write_on = (st == asc_pkg::ASC_WRITE);
	endfunction

	function automatic logic data_on(
		input asc_pkg::asc_state_e st
	);
		data_on = write_on(st) || (st == asc_pkg::ASC_WEND);
	endfunction

	function automatic logic read_on(
		input asc_pkg::asc_state_e st
	);
		read_on = (st == asc_pkg::ASC_READ);
	endfunction

	// ==========================================================
	// strobes
	// chip-select low only while a cycle is open
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_chip_sel_n <= 1'b1;
		end else if (clk_en) begin
			mem_chip_sel_n <= !sel_on(state_next);
		end
	end

	// strobe rises one cycle before chip-select: strobe ends it, so
	// the two never rise together and the float case cannot arise
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_write_n <= 1'b1;
		end else if (clk_en) begin
			mem_write_n <= !write_on(state_next);
		end
	end

	// output-drive held high while writing so the device never
	// drives during our data phase, and at the strobe rise
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_out_drive_n <= 1'b1;
		end else if (clk_en) begin
			mem_out_drive_n <= !read_on(state_next);
		end
	end

	// drive data through the strobe rise for hold
	always_ff @(posedge core_clk) begin
		if (reset) begin
			mem_data_oe <= 1'b0;
		end else if (clk_en) begin
			mem_data_oe <= data_on(state_next);
		end
	end

	// ==========================================================
	// read return
	// the byte is taken on the last read edge while output-drive is
	// still low; the turnaround that follows keeps our data drive off
	// until the device has let go of the pins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
		end else if (clk_en) begin
			rsp_valid <= 1'b0;
			if (state_reg == asc_pkg::ASC_READ && cnt_done) begin
				rsp_valid <= 1'b1;
				rsp_rdata <= mem_data_i;
			end
		end
	end

endmodule // asc_host
`default_nettype wire

// >>> asc_host_checker.sv
// checker: pin-order assertions of the sram host controller
`timescale 1ns/1ps
`default_nettype none
module asc_host_checker #(parameter int WR_CYC = 7, parameter int RD_CYC = 9) (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       rsp_valid,
	input wire logic       mem_chip_sel_n,
	input wire logic       mem_write_n,
	input wire logic       mem_out_drive_n,
	input wire logic [7:0] mem_data_o,
	input wire logic       mem_data_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_wr_in_sel: assert property (!mem_write_n |-> !mem_chip_sel_n)
		else $error("write strobe outside select");
	a_wr_pulse_len: assert property ($fell(mem_write_n)
		|-> ##WR_CYC $rose(mem_write_n)) else $error("write pulse length");
	a_strobe_first: assert property ($rose(mem_write_n)
		|-> !mem_chip_sel_n ##1 mem_chip_sel_n) else $error("strobe order");
	a_data_hold: assert property ($rose(mem_write_n)
		|-> mem_data_oe && $stable(mem_data_o)) else $error("data hold");
	a_no_clash: assert property (!mem_out_drive_n |-> !mem_data_oe)
		else $error("bus contention");
	a_wr_drive: assert property (!mem_write_n
		|-> mem_out_drive_n && mem_data_oe) else $error("write drive");
	a_rd_latency: assert property ($fell(mem_out_drive_n)
		|-> mem_write_n ##RD_CYC rsp_valid) else $error("read latency");
	a_desel_quiet: assert property (mem_chip_sel_n
		|-> mem_write_n && mem_out_drive_n && !mem_data_oe)
		else $error("deselected activity");
endmodule // asc_host_checker
bind asc_host asc_host_checker #(.WR_CYC(WR_CYC), .RD_CYC(RD_CYC)) chk_u (
	.core_clk(core_clk), .reset(reset), .rsp_valid(rsp_valid),
	.mem_chip_sel_n(mem_chip_sel_n), .mem_write_n(mem_write_n),
	.mem_out_drive_n(mem_out_drive_n), .mem_data_o(mem_data_o),
	.mem_data_oe(mem_data_oe));
`default_nettype wire

// >>> asc_sram_model.sv
// partner: behavioural byte-wide static memory on the host pins
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
	input wire logic [14:0] addr,
	input wire logic        cs_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic [7:0]  host_d,
	input wire logic        host_oe,
	output logic     [7:0]  pin_d
);
	logic [7:0] mem [asc_pkg::MEM_DEPTH];
	// whichever strobe rises first ends the write and takes the data
	always @(posedge we_n or posedge cs_n)
		if (!cs_n || !we_n) mem[addr] = host_d;
	// floating pins show the inverse, so a mistimed sample reads wrong
	assign pin_d = host_oe ? host_d
		: (!cs_n && we_n && !oe_n) ? mem[addr] : ~mem[addr];
endmodule // asc_sram_model
`default_nettype wire

// >>> asc_host_tb.sv
// testbench: writes, read-backs and a stall for the sram host controller
`timescale 1ns/1ps
`default_nettype none
module asc_host_tb;
	logic        core_clk = 0, reset = 1, clk_en = 1;
	logic        req_valid = 0, req_write = 0;
	logic [14:0] req_addr = '0, mem_addr;
	logic [7:0]  req_wdata = '0, rsp_rdata, mem_data_o, pin_d;
	logic        req_ready, rsp_valid, mem_data_oe;
	logic        mem_chip_sel_n, mem_write_n, mem_out_drive_n;
	logic [7:0]  exp_mem [logic [14:0]];
	int          num_errors = 0, samples_checked = 0;
	always #4 core_clk = ~core_clk;
	asc_host dut_u (.core_clk, .reset, .clk_en, .req_valid, .req_write,
		.req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
		.mem_chip_sel_n, .mem_write_n, .mem_out_drive_n, .mem_data_i(pin_d),
		.mem_data_o, .mem_data_oe);
	asc_sram_model mem_u (.addr(mem_addr), .cs_n(mem_chip_sel_n),
		.we_n(mem_write_n), .oe_n(mem_out_drive_n), .host_d(mem_data_o),
		.host_oe(mem_data_oe), .pin_d(pin_d));
	task automatic chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bounded wait at falling edges, where outputs have settled
	task automatic wait_for(ref logic sig);
		int n;
		n = 0;
		while (sig !== 1'b1) begin
			@(negedge core_clk);
			n++;
			if (n > 40) begin
				num_errors++;
				print_verdict();
			end
		end
	endtask
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(negedge core_clk);
		wait_for(req_ready);
		@(posedge core_clk);
		req_valid <= 1'b0;
		if (w) exp_mem[a] = d;
		else begin
			@(negedge core_clk);
			wait_for(rsp_valid);
			chk("read byte", exp_mem[a], rsp_rdata);
		end
	endtask
	// last entry rewrites the top address, so retention and overwrite show
	task automatic t_write_read;
		logic [14:0] a [5] = '{15'h0000, 15'h7fff, 15'h2aaa, 15'h5555, 15'h7fff};
		for (int i = 0; i < 5; i++) req(1'b1, a[i], 8'ha5 ^ a[i][7:0] ^ i[7:0]);
		for (int i = 0; i < 4; i++) req(1'b0, a[i], 8'h00);
		$display("write_read done");
	endtask
	task automatic t_stall;
		@(posedge core_clk);
		clk_en <= 1'b0;
		req_valid <= 1'b1;
		req_write <= 1'b0;
		req_addr <= 15'h2aaa;
		repeat (3) @(negedge core_clk);
		chk("ready held", 8'h00, {7'h00, req_ready});
		chk("select idle", 8'h01, {7'h00, mem_chip_sel_n});
		@(posedge core_clk);
		clk_en <= 1'b1;
		req_valid <= 1'b0;
		req(1'b0, 15'h2aaa, 8'h00);
		$display("stall done");
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		t_write_read();
		t_stall();
		print_verdict();
	end
endmodule // asc_host_tb
`default_nettype wire
